//--- bench/capture_compare_timer16_tb.sv
`timescale 1ns/1ps
// self-checking bench for the capture/compare timer
module capture_compare_timer16_tb import cct16_pkg::*;;
  logic clk, rst, psel, penable, pwrite, cpuMaskBit, haltMode, pready, pslverr, timerIrq, extPin, lastErr;
  logic [7:0] paddr, q;
  logic [31:0] pwdata, prdata;
  logic [1:0] capPins, compareOutputPin, compareOutputPinOeN;
  logic [15:0] cnt, v; // cnt mirrors the expected count in external mode
  int errCount, checked, n;
  logic [1:0] codes [3] = '{CLK_DIV2, CLK_DIV4, CLK_DIV8};
  int divs [3] = '{2, 4, 8};

  cct16_timer u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .captureInputPin(capPins),
    .extClockPin(extPin), .cpuMaskBit(cpuMaskBit), .haltMode(haltMode), .compareOutputPin(compareOutputPin),
    .compareOutputPinOeN(compareOutputPinOeN), .timerIrq(timerIrq));
  cct16_far_end u_far (.clk(clk), .captureInputPin(capPins), .extClockPin(extPin));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // verdict and end of run
  task automatic reportAndStop();
    if (errCount == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : reportAndStop

  // compare seen against expected
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errCount++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic isWr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] rdByte);
    int w;
    w = 0;
    psel <= 1'b1;
    pwrite <= isWr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      w++;
    end while (pready !== 1'b1 && w < 20);
    rdByte = prdata[7:0];
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (w >= 20) begin
      errCount++;
      reportAndStop();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00, q);
    check(q, exp);
  endtask : rd

  // status without the overflow bit
  task automatic rdSt(input logic [7:0] exp);
    apb(1'b0, ADDR_STATUS, 8'h00, q);
    check(q & 8'hd8, exp);
  endtask : rdSt

  // k rising edges on the external clock
  task automatic pulse(input int k);
    repeat (k) begin
      u_far.setExt(1'b1);
      u_far.setExt(1'b0);
    end
    cnt = cnt + 16'(k);
  endtask : pulse

  // low count byte after 64 running cycles at a divider
  function automatic logic [7:0] divLo(input int div);
    return CNT_RESET[7:0] + 8'(64 / div);
  endfunction : divLo

  // within one count of the expectation, prescaler phase unknown
  function automatic logic tolOk(input logic [7:0] seen, input logic [7:0] exp);
    logic [7:0] dif;
    dif = seen - exp;
    return (dif == 8'h00) || (dif == 8'h01) || (dif == 8'hff);
  endfunction : tolOk

  // main sequence
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    cpuMaskBit = 1'b1; haltMode = 1'b1; errCount = 0; checked = 0;
    void'($urandom(38022));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADDR_CMP1_HI, 8'h80);
    rd(ADDR_CMP2_LO, 8'h00);
    check(8'(compareOutputPin), 8'h00);
    apb(1'b0, 8'h3c, 8'h00, q);
    check({q[6:0], lastErr}, 8'h01);
    // dividers: reload frozen, run 64 cycles, freeze, read
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL2, {4'h0, codes[i], 2'h0});
      wr(ADDR_CNT_LO, 8'h00);
      haltMode <= 1'b0;
      repeat (64) @(posedge clk);
      haltMode <= 1'b1;
      apb(1'b0, ADDR_CNT_LO, 8'h00, q);
      check(8'(tolOk(q, divLo(divs[i]))), 8'h01);
      v[7:0] = q;
      rd(ADDR_CNT_HI, 8'h00);
      repeat (20) @(posedge clk);
      rd(ADDR_CNT_LO, v[7:0]);
      rd(ADDR_ALT_LO, v[7:0]);
    end
    rd(ADDR_STATUS, 8'h20);
    wr(ADDR_CTRL1, 8'h20);
    repeat (3) @(posedge clk);
    check(8'(timerIrq), 8'h00);
    cpuMaskBit <= 1'b0;
    repeat (3) @(posedge clk);
    check(8'(timerIrq), 8'h01);
    rd(ADDR_STATUS, 8'h20);
    apb(1'b0, ADDR_ALT_LO, 8'h00, q);
    rd(ADDR_STATUS, 8'h20);
    apb(1'b0, ADDR_CNT_LO, 8'h00, q);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_CTRL1, 8'h00);
    // external clock, rising then falling edge selected
    for (int e = 1; e >= 0; e--) begin
      wr(ADDR_CTRL2, {4'h0, CLK_EXT, 1'b0, 1'(e)});
      haltMode <= 1'b0;
      wr(ADDR_CNT_LO, 8'h00);
      cnt = CNT_RESET;
      pulse(3);
      u_far.setExt(1'b1);
      rd(ADDR_CNT_HI, (e == 1) ? 8'h00 : 8'hff);
      rd(ADDR_CNT_LO, (e == 1) ? 8'h00 : 8'hff);
      u_far.setExt(1'b0);
    end
    // capture: channel one rising, channel two falling
    wr(ADDR_CTRL2, 8'h8d);
    wr(ADDR_CNT_LO, 8'h00);
    cnt = CNT_RESET;
    pulse($urandom_range(1, 6));
    wr(ADDR_CTRL1, 8'h82);
    u_far.setCap(0, 1'b1);
    rdSt(8'h80);
    check(8'(timerIrq), 8'h01);
    v = cnt;
    rd(ADDR_CAP1_HI, v[15:8]);
    pulse(2);
    u_far.setCap(0, 1'b0);
    u_far.setCap(0, 1'b1);
    rdSt(8'h80);
    rd(ADDR_CAP1_LO, v[7:0]);
    rdSt(8'h00);
    u_far.setCap(1, 1'b1);
    rdSt(8'h00);
    u_far.setCap(1, 1'b0);
    rdSt(8'h10);
    rd(ADDR_CAP2_HI, cnt[15:8]);
    rd(ADDR_CAP2_LO, cnt[7:0]);
    rdSt(8'h00);
    // compare channel one, pin enabled, external clock matches one count late
    wr(ADDR_CTRL1, 8'h41);
    v = cnt + 16'h2;
    wr(ADDR_CMP1_HI, v[15:8]);
    wr(ADDR_CMP1_LO, v[7:0]);
    pulse(2);
    rdSt(8'h00);
    check(8'(compareOutputPin), 8'h00);
    pulse(1);
    rdSt(8'h40);
    check({6'h0, compareOutputPinOeN[0], compareOutputPin[0]}, 8'h01);
    check(8'(timerIrq), 8'h01);
    wr(ADDR_CMP1_LO, v[7:0]);
    rdSt(8'h00);
    // high write alone suspends matching
    wr(ADDR_CTRL1, 8'h40);
    v = cnt + 16'h2;
    wr(ADDR_CMP1_HI, v[15:8]);
    wr(ADDR_CMP1_LO, v[7:0]);
    wr(ADDR_CMP1_HI, v[15:8]);
    pulse(3);
    rdSt(8'h00);
    check(8'(compareOutputPin[0]), 8'h01);
    // step past the target so the resumed compare stays quiet
    pulse(1);
    wr(ADDR_CMP1_LO, v[7:0]);
    wr(ADDR_CTRL1, 8'h48);
    repeat (2) @(posedge clk);
    check({timerIrq, 6'h0, compareOutputPin[0]}, 8'h00);
    rdSt(8'h00);
    // channel two with its pin disabled still flags and interrupts
    wr(ADDR_CTRL1, 8'h44);
    v = cnt + 16'h2;
    wr(ADDR_CMP2_HI, v[15:8]);
    wr(ADDR_CMP2_LO, v[7:0]);
    pulse(3);
    rdSt(8'h08);
    check({timerIrq, 5'h0, compareOutputPinOeN[1], compareOutputPin[1]}, 8'h82);
    rd(ADDR_CMP2_LO, v[7:0]);
    rdSt(8'h00);
    // reset while halted: the count restarts from its reset value
    haltMode <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({6'h0, compareOutputPinOeN}, 8'h03);
    rd(ADDR_CNT_HI, CNT_RESET[15:8]);
    rd(ADDR_CNT_LO, CNT_RESET[7:0]);
    check(8'(compareOutputPin), 8'h00);
    reportAndStop();
  end
endmodule : capture_compare_timer16_tb

//--- bench/cct16_far_end.sv
`timescale 1ns/1ps
// far side of the timer pins: capture sources and the external count clock
module cct16_far_end import cct16_pkg::*; (
  input wire logic clk,
  output logic [1:0] captureInputPin,
  output logic extClockPin
);
  // quiet pins at time zero
  initial begin
    captureInputPin = 2'h0;
    extClockPin = 1'b0;
  end

  // one level change, then rest long enough for the synchroniser and the edge spacing
  task automatic setExt(input logic lvl);
    @(posedge clk);
    extClockPin <= lvl;
    repeat (EXT_MIN_GAP + 2) @(posedge clk);
  endtask : setExt

  // one capture pin change, then wait past the three-cycle detection delay
  task automatic setCap(input int ch, input logic lvl);
    @(posedge clk);
    captureInputPin[ch] <= lvl;
    repeat (6) @(posedge clk);
  endtask : setCap
endmodule : cct16_far_end

//--- common/cct16_pkg.sv
// Notes on behaviour
// - high counter read freezes low byte
// - lone low read returns live count
// - wrap to zero sets overflow flag
// - overflow request gated by enable and mask
// - overflow clears: status read, counter low access
// - alternate low access keeps overflow flag
// - wait runs, halt freezes counter
// - clock select three picks external edge
// - capture edge copies counter, sets flag
// - per channel capture edge select bits
// - shared capture enable, mask gated request
// - capture flag clears: status, low access
// - capture high read inhibits until low read
// - capture pins always feed the timer
// - match sets flag, pin, interrupt
// - compare registers reset to midpoint, pin low
// - compare flag clears: status, low access
// - compare high write suspends until low write
// - pin disabled: no drive, interrupt still
// - half clock equal, else equal plus one
// - force copies level, no flag, not modes
// - counter low write reloads reset value
// - timer clock divide two four eight external
package cct16_pkg;
  // byte addresses of the word-wide register slots
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CAP1_HI = 8'h0c;
  localparam logic [7:0] ADDR_CAP1_LO = 8'h10;
  localparam logic [7:0] ADDR_CMP1_HI = 8'h14;
  localparam logic [7:0] ADDR_CMP1_LO = 8'h18;
  localparam logic [7:0] ADDR_CAP2_HI = 8'h1c;
  localparam logic [7:0] ADDR_CAP2_LO = 8'h20;
  localparam logic [7:0] ADDR_CMP2_HI = 8'h24;
  localparam logic [7:0] ADDR_CMP2_LO = 8'h28;
  localparam logic [7:0] ADDR_CNT_HI = 8'h2c;
  localparam logic [7:0] ADDR_CNT_LO = 8'h30;
  localparam logic [7:0] ADDR_ALT_HI = 8'h34;
  localparam logic [7:0] ADDR_ALT_LO = 8'h38;
  // control one field positions
  localparam int C1_CAP_IE = 7;
  localparam int C1_CMP_IE = 6;
  localparam int C1_OVF_IE = 5;
  localparam int C1_FORCE2 = 4;
  localparam int C1_FORCE1 = 3;
  localparam int C1_LEVEL2 = 2;
  localparam int C1_EDGE1 = 1;
  localparam int C1_LEVEL1 = 0;
  // control two field positions
  localparam int C2_PIN1_EN = 7;
  localparam int C2_PIN2_EN = 6;
  localparam int C2_ONE_PULSE = 5;
  localparam int C2_PWM = 4;
  localparam int C2_CLK_HI = 3;
  localparam int C2_CLK_LO = 2;
  localparam int C2_EDGE2 = 1;
  localparam int C2_EXT_EDGE = 0;
  // status field positions
  localparam int ST_CAP1 = 7;
  localparam int ST_CMP1 = 6;
  localparam int ST_OVF = 5;
  localparam int ST_CAP2 = 4;
  localparam int ST_CMP2 = 3;
  // clock select codes
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  // reset values and counter maximum
  localparam logic [15:0] CNT_RESET = 16'hfffc;
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] OEN_RESET = 2'h3;
  // least external edge spacing in cpu clocks
  localparam int EXT_MIN_GAP = 4;
endpackage : cct16_pkg

//--- rtl/cct16_timer.sv
`timescale 1ns/1ps
module cct16_timer import cct16_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] captureInputPin,
  input wire logic extClockPin,
  input wire logic cpuMaskBit,
  input wire logic haltMode,
  output logic [1:0] compareOutputPin,
  output logic [1:0] compareOutputPinOeN,
  output logic timerIrq
);
  // bus flops
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  // control and status
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic overflowFlag_q;
  logic [1:0] captureFlag_q;
  logic [1:0] compareFlag_q;
  logic [4:0] armed_q;
  // counter and read buffer
  logic [15:0] count_q;
  logic [7:0] lowBuf_q;
  logic seqOpen_q;
  logic [2:0] presc_q;
  // external clock synchroniser
  logic [2:0] extSync_q;
  // per channel state
  logic [15:0] capVal_q [2];
  logic [15:0] cmpVal_q [2];
  logic [1:0] capInhibit_q;
  logic [1:0] cmpInhibit_q;
  logic [2:0] capSync_q [2];
  logic [1:0] matchPrev_q;
  logic [1:0] pin_q;
  logic irq_q;
  logic [1:0] oeN_q; // registered pin drive enables, low = timer drives

  // bus phase decode
  wire setupSeen = psel & penable & ~pready_q;
  wire done = psel & penable & pready_q;
  wire wrDone = done & pwrite;
  wire rdDone = done & ~pwrite;
  wire [7:0] wbyte = pwdata[7:0];
  // address hits
  wire hitCtrl1 = paddr == ADDR_CTRL1;
  wire hitCtrl2 = paddr == ADDR_CTRL2;
  wire hitStatus = paddr == ADDR_STATUS;
  wire hitCntHi = paddr == ADDR_CNT_HI;
  wire hitCntLo = paddr == ADDR_CNT_LO;
  wire hitAltHi = paddr == ADDR_ALT_HI;
  wire hitAltLo = paddr == ADDR_ALT_LO;
  wire [1:0] hitCapHi = {paddr == ADDR_CAP2_HI, paddr == ADDR_CAP1_HI};
  wire [1:0] hitCapLo = {paddr == ADDR_CAP2_LO, paddr == ADDR_CAP1_LO};
  wire [1:0] hitCmpHi = {paddr == ADDR_CMP2_HI, paddr == ADDR_CMP1_HI};
  wire [1:0] hitCmpLo = {paddr == ADDR_CMP2_LO, paddr == ADDR_CMP1_LO};
  wire mapped = hitCtrl1 | hitCtrl2 | hitStatus | hitCntHi | hitCntLo | hitAltHi | hitAltLo
    | (|hitCapHi) | (|hitCapLo) | (|hitCmpHi) | (|hitCmpLo);
  // status byte view
  wire [7:0] statusByte = {captureFlag_q[0], compareFlag_q[0], overflowFlag_q, captureFlag_q[1],
    compareFlag_q[1], 3'h0};
  // low byte of either counter view: frozen while a sequence is open
  wire [7:0] cntLowView = seqOpen_q ? lowBuf_q : count_q[7:0];
  wire [7:0] readByte;
  assign readByte = hitCtrl1 ? ctrl1_q
    : hitCtrl2 ? ctrl2_q
    : hitStatus ? statusByte
    : (hitCntHi | hitAltHi) ? count_q[15:8]
    : (hitCntLo | hitAltLo) ? cntLowView
    : hitCapHi[0] ? capVal_q[0][15:8]
    : hitCapLo[0] ? capVal_q[0][7:0]
    : hitCapHi[1] ? capVal_q[1][15:8]
    : hitCapLo[1] ? capVal_q[1][7:0]
    : hitCmpHi[0] ? cmpVal_q[0][15:8]
    : hitCmpLo[0] ? cmpVal_q[0][7:0]
    : hitCmpHi[1] ? cmpVal_q[1][15:8]
    : hitCmpLo[1] ? cmpVal_q[1][7:0]
    : 8'h00;

  // timer tick generation
  wire [1:0] clkSel = ctrl2_q[C2_CLK_HI:C2_CLK_LO];
  wire extEdgeSeen = ctrl2_q[C2_EXT_EDGE] ? (extSync_q[1] & ~extSync_q[2])
    : (~extSync_q[1] & extSync_q[2]);
  wire prescTick = (clkSel == CLK_DIV2) ? presc_q[0]
    : (clkSel == CLK_DIV4) ? (presc_q[1:0] == 2'h3)
    : (presc_q == 3'h7);
  wire tick = (clkSel == CLK_EXT) ? extEdgeSeen : prescTick;
  wire runCount = tick & ~haltMode;
  wire cntReload = wrDone & (hitCntLo | hitAltLo);
  wire wrapNow = runCount & (count_q == CNT_MAX) & ~cntReload;
  // flag clearing by second step of the sequence
  wire ovfClear = done & hitCntLo & armed_q[ST_OVF - 3];
  wire modeActive = ctrl2_q[C2_ONE_PULSE] | ctrl2_q[C2_PWM];
  wire [1:0] forceNow = {2{wrDone & hitCtrl1 & ~modeActive}}
    & {wbyte[C1_FORCE2], wbyte[C1_FORCE1]};
  wire [1:0] levelNow = {wbyte[C1_LEVEL2], wbyte[C1_LEVEL1]};
  wire [1:0] levelBit = {ctrl1_q[C1_LEVEL2], ctrl1_q[C1_LEVEL1]};
  wire [1:0] pinEnable = {ctrl2_q[C2_PIN2_EN], ctrl2_q[C2_PIN1_EN]};
  wire [1:0] edgeSel = {ctrl2_q[C2_EDGE2], ctrl1_q[C1_EDGE1]};
  wire [1:0] armCap = {armed_q[ST_CAP2 - 3], armed_q[ST_CAP1 - 3]};
  wire [1:0] armCmp = {armed_q[ST_CMP2 - 3], armed_q[ST_CMP1 - 3]};
  // per channel strobes, driven inside the generate loop
  wire [1:0] capEvent;
  wire [1:0] capClear;
  wire [1:0] cmpEvent;
  wire [1:0] cmpClear;
  wire [1:0] matchNow;

  // per channel capture and compare logic
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      // pins always feed the edge detector
      wire capEdge = edgeSel[ch] ? (capSync_q[ch][1] & ~capSync_q[ch][2])
        : (~capSync_q[ch][1] & capSync_q[ch][2]);
      assign capEvent[ch] = capEdge & ~capInhibit_q[ch];
      assign capClear[ch] = done & hitCapLo[ch] & armCap[ch];
      // half clock compares equal, slower clocks one beyond
      wire [15:0] target = (clkSel == CLK_DIV2) ? cmpVal_q[ch]
        : 16'(cmpVal_q[ch] + 16'h0001);
      assign matchNow[ch] = (count_q == target) & ~cmpInhibit_q[ch];
      assign cmpEvent[ch] = matchNow[ch] & ~matchPrev_q[ch] & ~modeActive;
      assign cmpClear[ch] = done & hitCmpLo[ch] & armCmp[ch];
      // capture input synchroniser and edge history
      always_ff @(posedge clk) begin
        if (rst) begin
          capSync_q[ch] <= 3'h0;
        end else begin
          capSync_q[ch] <= {capSync_q[ch][1:0], captureInputPin[ch]};
        end
      end
      // capture value and read inhibit
      always_ff @(posedge clk) begin
        if (rst) begin
          capVal_q[ch] <= 16'h0000;
          capInhibit_q[ch] <= 1'b0;
        end else begin
          if (capEvent[ch]) capVal_q[ch] <= count_q;
          if (rdDone & hitCapHi[ch]) capInhibit_q[ch] <= 1'b1;
          else if (rdDone & hitCapLo[ch]) capInhibit_q[ch] <= 1'b0;
        end
      end
      // compare value, inhibit and match history
      always_ff @(posedge clk) begin
        if (rst) begin
          cmpVal_q[ch] <= CMP_RESET;
          cmpInhibit_q[ch] <= 1'b0;
          matchPrev_q[ch] <= 1'b0;
        end else begin
          if (wrDone & hitCmpHi[ch]) cmpVal_q[ch][15:8] <= wbyte;
          if (wrDone & hitCmpLo[ch]) cmpVal_q[ch][7:0] <= wbyte;
          if (wrDone & hitCmpHi[ch]) cmpInhibit_q[ch] <= 1'b1;
          else if (wrDone & hitCmpLo[ch]) cmpInhibit_q[ch] <= 1'b0;
          matchPrev_q[ch] <= matchNow[ch];
        end
      end
      // output pin latch: force, then match when enabled
      always_ff @(posedge clk) begin
        if (rst) begin
          pin_q[ch] <= 1'b0;
        end else if (forceNow[ch]) begin
          pin_q[ch] <= levelNow[ch];
        end else if (cmpEvent[ch] & pinEnable[ch]) begin
          pin_q[ch] <= levelBit[ch];
        end
      end
    end
  endgenerate

  // interrupt request from enabled flags and cpu mask
  wire irqReq = ((overflowFlag_q & ctrl1_q[C1_OVF_IE])
    | ((|captureFlag_q) & ctrl1_q[C1_CAP_IE])
    | ((|compareFlag_q) & ctrl1_q[C1_CMP_IE])) & ~cpuMaskBit;

  // apb answer: one wait state then ready
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setupSeen;
      pslverr_q <= setupSeen & ~mapped;
      if (setupSeen & ~pwrite) prdata_q <= {24'h000000, readByte};
    end
  end

  // control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl1_q <= CTRL_RESET;
      ctrl2_q <= CTRL_RESET;
    end else begin
      if (wrDone & hitCtrl1) ctrl1_q <= wbyte;
      if (wrDone & hitCtrl2) ctrl2_q <= wbyte;
    end
  end

  // pin drive enables follow the control two write, so the pins come from a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      oeN_q <= OEN_RESET;
    end else if (wrDone & hitCtrl2) begin
      oeN_q <= ~{wbyte[C2_PIN2_EN], wbyte[C2_PIN1_EN]};
    end
  end

  // prescaler and external clock synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      presc_q <= 3'h0;
      extSync_q <= 3'h0;
    end else begin
      // the prescaler stops with the counter in halt
      if (~haltMode) presc_q <= 3'(presc_q + 3'h1);
      extSync_q <= {extSync_q[1:0], extClockPin};
    end
  end

  // free running counter
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= CNT_RESET;
    end else if (cntReload) begin
      count_q <= CNT_RESET;
    end else if (runCount) begin
      count_q <= 16'(count_q + 16'h0001);
    end
  end

  // coherent 16-bit read buffer
  always_ff @(posedge clk) begin
    if (rst) begin
      lowBuf_q <= 8'h00;
      seqOpen_q <= 1'b0;
    end else if (rdDone & (hitCntHi | hitAltHi)) begin
      // repeated high reads keep the first buffered byte
      if (~seqOpen_q) lowBuf_q <= count_q[7:0];
      seqOpen_q <= 1'b1;
    end else if (rdDone & (hitCntLo | hitAltLo)) begin
      seqOpen_q <= 1'b0;
    end
  end

  // status flags: set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      overflowFlag_q <= 1'b0;
      captureFlag_q <= 2'h0;
      compareFlag_q <= 2'h0;
      armed_q <= 5'h00;
      irq_q <= 1'b0;
    end else begin
      overflowFlag_q <= wrapNow | (overflowFlag_q & ~ovfClear);
      captureFlag_q <= capEvent | (captureFlag_q & ~capClear);
      compareFlag_q <= cmpEvent | (compareFlag_q & ~cmpClear);
      // a status read arms every flag that it saw set
      if (rdDone & hitStatus) armed_q <= armed_q | statusByte[7:3];
      else armed_q <= armed_q & ~{capClear[0], cmpClear[0], ovfClear, capClear[1], cmpClear[1]};
      irq_q <= irqReq;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign compareOutputPin = pin_q;
  assign compareOutputPinOeN = oeN_q;
  assign timerIrq = irq_q;

  // checks
  ovf_set_wrap_a: assert property (@(posedge clk) disable iff (rst) wrapNow |=> overflowFlag_q)
    else $error("overflow flag not set on wrap");
  alt_keeps_ovf_a: assert property (@(posedge clk) disable iff (rst)
    (done & hitAltLo & overflowFlag_q) |=> overflowFlag_q)
    else $error("alternate access cleared overflow");
  ovf_needs_arm_a: assert property (@(posedge clk) disable iff (rst)
    (overflowFlag_q & ~armed_q[ST_OVF - 3]) |=> overflowFlag_q)
    else $error("overflow cleared without status read");
  low_frozen_a: assert property (@(posedge clk) disable iff (rst)
    (rdDone & hitCntHi & ~seqOpen_q) |=> (seqOpen_q && lowBuf_q == $past(count_q[7:0])))
    else $error("low byte not buffered");
  reload_value_a: assert property (@(posedge clk) disable iff (rst) cntReload |=> count_q == CNT_RESET)
    else $error("counter reload wrong");
  halt_freeze_a: assert property (@(posedge clk) disable iff (rst)
    (haltMode & ~cntReload) |=> $stable(count_q))
    else $error("counter moved in halt");
  count_step_a: assert property (@(posedge clk) disable iff (rst)
    (runCount & ~cntReload) |=> count_q == 16'($past(count_q) + 16'h0001))
    else $error("counter step wrong");
  cap_latch_a: assert property (@(posedge clk) disable iff (rst)
    capEvent[0] |=> (capVal_q[0] == $past(count_q) && captureFlag_q[0]))
    else $error("capture not latched");
  cap_inhibit_a: assert property (@(posedge clk) disable iff (rst)
    capInhibit_q[1] |=> ($stable(capVal_q[1]) && !$rose(captureFlag_q[1])))
    else $error("capture during inhibit");
  cmp_suspend_a: assert property (@(posedge clk) disable iff (rst)
    (wrDone & hitCmpHi[0]) |=> ~cmpEvent[0])
    else $error("compare not suspended");
  force_noflag_a: assert property (@(posedge clk) disable iff (rst)
    (forceNow[1] & ~cmpEvent[1] & ~compareFlag_q[1]) |=> (~compareFlag_q[1] && pin_q[1] == $past(levelNow[1])))
    else $error("force set flag or missed pin");
  irq_mask_a: assert property (@(posedge clk) disable iff (rst)
    (overflowFlag_q & ctrl1_q[C1_OVF_IE] & ~cpuMaskBit) |=> timerIrq)
    else $error("overflow interrupt missing");

  // bus and counter checks
  live_low_a: assert property (@(posedge clk) disable iff (rst)
    (setupSeen & ~pwrite & hitCntLo & ~seqOpen_q) |=> prdata[7:0] == $past(count_q[7:0]))
    else $error("live low byte wrong");
  ext_only_a: assert property (@(posedge clk) disable iff (rst)
    ((clkSel == CLK_EXT) & ~extEdgeSeen & ~cntReload) |=> $stable(count_q))
    else $error("counter moved without external edge");
  div2_rate_a: assert property (@(posedge clk) disable iff (rst)
    ((clkSel == CLK_DIV2) & ~haltMode & ~cntReload) [*2] |=> count_q == 16'($past(count_q, 2) + 16'h0001))
    else $error("half clock rate wrong");

  // capture checks
  cap_latch_two_a: assert property (@(posedge clk) disable iff (rst)
    capEvent[1] |=> (capVal_q[1] == $past(count_q) && captureFlag_q[1]))
    else $error("second capture not latched");
  cap_irq_a: assert property (@(posedge clk) disable iff (rst)
    ((|captureFlag_q) & ctrl1_q[C1_CAP_IE] & ~cpuMaskBit) |=> timerIrq)
    else $error("capture interrupt missing");
  cap_needs_arm_a: assert property (@(posedge clk) disable iff (rst)
    (captureFlag_q[0] & ~armCap[0]) |=> captureFlag_q[0])
    else $error("capture flag cleared without status read");
  cap_clear_a: assert property (@(posedge clk) disable iff (rst)
    (capClear[1] & ~capEvent[1]) |=> ~captureFlag_q[1])
    else $error("capture flag not cleared");
  edge_pick_a: assert property (@(posedge clk) disable iff (rst)
    (capSync_q[0][1] & ~capSync_q[0][2] & ~edgeSel[0]) |-> ~capEvent[0])
    else $error("capture on unselected edge");

  // compare and pin checks
  match_drive_a: assert property (@(posedge clk) disable iff (rst)
    (cmpEvent[0] & pinEnable[0] & ~forceNow[0]) |=> (compareFlag_q[0] && compareOutputPin[0] == $past(levelBit[0])))
    else $error("match missed flag or pin");
  late_match_a: assert property (@(posedge clk) disable iff (rst)
    ((clkSel != CLK_DIV2) & (count_q == cmpVal_q[0])) |-> ~matchNow[0])
    else $error("slow clock matched too early");
  cmp_needs_arm_a: assert property (@(posedge clk) disable iff (rst)
    (compareFlag_q[1] & ~armCmp[1]) |=> compareFlag_q[1])
    else $error("compare flag cleared without status read");
  cmp_clear_a: assert property (@(posedge clk) disable iff (rst)
    (cmpClear[0] & ~cmpEvent[0]) |=> ~compareFlag_q[0])
    else $error("compare flag not cleared");
  cmp_sw_only_a: assert property (@(posedge clk) disable iff (rst)
    ~(wrDone & (hitCmpHi[1] | hitCmpLo[1])) |=> $stable(cmpVal_q[1]))
    else $error("compare value changed without write");
  pin_hold_a: assert property (@(posedge clk) disable iff (rst)
    (~pinEnable[1] & ~forceNow[1]) |=> $stable(compareOutputPin[1]))
    else $error("disabled pin moved");
  oe_follow_a: assert property (@(posedge clk) disable iff (rst)
    compareOutputPinOeN == ~pinEnable)
    else $error("pin drive enable wrong");

  // covers of the main scenarios
  wrap_cover_c: cover property (@(posedge clk) disable iff (rst) wrapNow);
  capture_cover_c: cover property (@(posedge clk) disable iff (rst) capEvent[1]);
  match_cover_c: cover property (@(posedge clk) disable iff (rst) cmpEvent[0] & pinEnable[0]);
  ovf_clear_cover_c: cover property (@(posedge clk) disable iff (rst) ovfClear);
  force_cover_c: cover property (@(posedge clk) disable iff (rst) forceNow[0]);
endmodule : cct16_timer
